// *** hw/kmc_pkg.sv ***
// constants and state layout for the keyboard and mouse configuration bank
// assumes a 250 MHz system clock and an APB master with 32-bit data
package kmc_pkg;

	// -------------------------------------------------------------------
	// register indices; byte address on APB is four times the index
	// -------------------------------------------------------------------
	localparam logic [7:0] IDX_LDN = 8'h07;
	localparam logic [7:0] IDX_ACT = 8'h30;
	localparam logic [7:0] IDX_DBASE_HI = 8'h60;
	localparam logic [7:0] IDX_DBASE_LO = 8'h61;
	localparam logic [7:0] IDX_CBASE_HI = 8'h62;
	localparam logic [7:0] IDX_CBASE_LO = 8'h63;
	localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
	localparam logic [7:0] IDX_DMA_A = 8'h74;
	localparam logic [7:0] IDX_DMA_B = 8'h75;
	localparam logic [7:0] IDX_CFG = 8'hF0;

	// logical device numbers selected through IDX_LDN
	localparam logic [7:0] LDN_MOUSE = 8'h05;
	localparam logic [7:0] LDN_KBD = 8'h06;

	// -------------------------------------------------------------------
	// reset values and the fixed DMA report value
	// -------------------------------------------------------------------
	localparam logic [7:0] RST_LDN = 8'h06;
	localparam logic [7:0] RST_MOUSE_ACT = 8'h00;
	localparam logic [7:0] RST_KBD_ACT = 8'h01;
	localparam logic [7:0] RST_DBASE_HI = 8'h00;
	localparam logic [7:0] RST_DBASE_LO = 8'h60;
	localparam logic [7:0] RST_CBASE_HI = 8'h00;
	localparam logic [7:0] RST_CBASE_LO = 8'h64;
	localparam logic [7:0] RST_MOUSE_IRQ_NUM = 8'h0C;
	localparam logic [7:0] RST_KBD_IRQ_NUM = 8'h01;
	localparam logic [7:0] RST_IRQ_TYPE = 8'h02;
	localparam logic [7:0] RST_CFG = 8'h40;
	localparam logic [7:0] DMA_NONE = 8'h04;

	// -------------------------------------------------------------------
	// field positions and fixed bits
	// -------------------------------------------------------------------
	localparam int ACT_BIT = 0;
	localparam int TYPE_MSB = 1;
	localparam int BASE_HI_MSB = 2;
	localparam int BASE_LO_LSB = 3;
	localparam int CFG_CLK_MSB = 7;
	localparam int CFG_CLK_LSB = 6;
	localparam int CFG_TRI_BIT = 0;
	localparam logic [2:0] DBASE_LO_FIXED = 3'b000;
	localparam logic [2:0] CBASE_LO_FIXED = 3'b100;

	// pin order in the four-bit pin vectors
	localparam int NUM_PINS = 4;
	localparam int PIN_TYP_CLK = 0;
	localparam int PIN_TYP_DAT = 1;
	localparam int PIN_PTR_CLK = 2;
	localparam int PIN_PTR_DAT = 3;
	localparam int NUM_IRQ = 16;

	typedef enum logic [1:0] {
		CLK_8MHZ = 2'b00,
		CLK_12MHZ = 2'b01,
		CLK_16MHZ = 2'b10,
		CLK_RSVD = 2'b11
	} kmc_clk_sel_t;

	typedef struct packed {
		logic [7:0] ldn;
		logic mouse_act;
		logic kbd_act;
		logic [2:0] dbase_hi;
		logic [4:0] dbase_lo;
		logic [2:0] cbase_hi;
		logic [4:0] cbase_lo;
		logic [7:0] m_num;
		logic [7:0] k_num;
		logic [1:0] m_type;
		logic [1:0] k_type;
		kmc_clk_sel_t clk_sel;
		logic tri_en;
		logic [31:0] prdata;
		logic pslverr;
		logic [NUM_IRQ-1:0] irq;
		logic [NUM_PINS-1:0] pin_oe;
	} kmc_state_t;

endpackage

// *** hw/kmc_sync.sv ***
// two-flop synchroniser, one stage pair per pin bit
// assumes asynchronous pin levels and a clock enable from the system domain
`timescale 1ns/1ns
`default_nettype none
module kmc_sync #(
	parameter int WIDTH = 4
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// -------------------------------------------------------------------
	// stages
	// -------------------------------------------------------------------
	// pins idle high (open drain with pull-up), so reset to one
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_r;
			logic sync_r;
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
				end else if (i_ce) begin
					meta_r <= i_async[g];
					sync_r <= meta_r;
				end
			end
			assign o_sync[g] = sync_r;
		end
	endgenerate

endmodule
`default_nettype wire

// *** hw/kmc_config_bank.sv ***
// configuration bank for the mouse and keyboard logical devices
// assumes an APB3 master, a controller core on the same clock that raises
// interrupt requests and pulls the open-drain pins, and a pad ring that
// resolves the pins from the output enables
`timescale 1ns/1ns
`default_nettype none

module kmc_config_bank
	import kmc_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	input wire logic I_CE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic O_PREADY,
	output logic [31:0] O_PRDATA,
	output logic O_PSLVERR,
	input wire logic I_KBD_IRQ_REQ,
	input wire logic I_MOUSE_IRQ_REQ,
	output logic [NUM_IRQ-1:0] O_IRQ,
	output logic [1:0] O_KBD_IRQ_TYPE,
	output logic [1:0] O_MOUSE_IRQ_TYPE,
	output logic O_KBD_ACTIVE,
	output logic O_MOUSE_ACTIVE,
	output logic [1:0] O_CLK_SEL,
	output logic O_CLK_SEL_OK,
	output logic [15:0] O_KBD_DATA_BASE,
	output logic [15:0] O_KBD_CMD_BASE,
	input wire logic [NUM_PINS-1:0] I_CORE_PULL_LOW,
	output logic [NUM_PINS-1:0] O_CORE_PIN_IN,
	input wire logic [NUM_PINS-1:0] I_DEV_PIN_IN,
	output logic [NUM_PINS-1:0] O_DEV_PIN_O,
	output logic [NUM_PINS-1:0] O_DEV_PIN_OE
);

	// -------------------------------------------------------------------
	// state and decode
	// -------------------------------------------------------------------
	kmc_state_t s_r;
	kmc_state_t s_nxt;
	kmc_state_t rst_state;
	logic [7:0] idx;
	logic addr_ok;
	logic setup;
	logic access;
	logic rd_hit;
	logic [7:0] rd_data;
	logic [7:0] wd;
	logic [1:0] wd_clk;

	assign idx = I_PADDR[9:2];
	assign addr_ok = (I_PADDR[1:0] == 2'b00) && (I_PADDR[11:10] == 2'b00);
	assign setup = I_PSEL && !I_PENABLE;
	assign access = I_PSEL && I_PENABLE;
	assign wd = I_PWDATA[7:0];
	assign wd_clk = I_PWDATA[CFG_CLK_MSB:CFG_CLK_LSB];

	always_comb begin
		rst_state = '0;
		rst_state.ldn = RST_LDN;
		rst_state.mouse_act = RST_MOUSE_ACT[ACT_BIT];
		rst_state.kbd_act = RST_KBD_ACT[ACT_BIT];
		rst_state.dbase_hi = RST_DBASE_HI[BASE_HI_MSB:0];
		rst_state.dbase_lo = RST_DBASE_LO[7:BASE_LO_LSB];
		rst_state.cbase_hi = RST_CBASE_HI[BASE_HI_MSB:0];
		rst_state.cbase_lo = RST_CBASE_LO[7:BASE_LO_LSB];
		rst_state.m_num = RST_MOUSE_IRQ_NUM;
		rst_state.k_num = RST_KBD_IRQ_NUM;
		rst_state.m_type = RST_IRQ_TYPE[TYPE_MSB:0];
		rst_state.k_type = RST_IRQ_TYPE[TYPE_MSB:0];
		rst_state.clk_sel = kmc_clk_sel_t'(RST_CFG[CFG_CLK_MSB:CFG_CLK_LSB]);
		rst_state.tri_en = RST_CFG[CFG_TRI_BIT];
	end

	// -------------------------------------------------------------------
	// read decode
	// -------------------------------------------------------------------
	// a logical device number other than mouse or keyboard maps nothing
	// but the selector itself, so software can always recover
	always_comb begin
		rd_hit = 1'b0;
		rd_data = 8'h00;
		if (addr_ok && idx == IDX_LDN) begin
			rd_hit = 1'b1;
			rd_data = s_r.ldn;
		end else if (addr_ok && s_r.ldn == LDN_MOUSE) begin
			case (idx)
				IDX_ACT: begin
					rd_hit = 1'b1;
					rd_data = {7'h00, s_r.mouse_act};
				end
				IDX_IRQ_NUM: begin
					rd_hit = 1'b1;
					rd_data = s_r.m_num;
				end
				IDX_IRQ_TYPE: begin
					rd_hit = 1'b1;
					rd_data = {6'h00, s_r.m_type};
				end
				IDX_DMA_A, IDX_DMA_B: begin
					rd_hit = 1'b1;
					rd_data = DMA_NONE;
				end
				default: begin
					rd_hit = 1'b0;
				end
			endcase
		end else if (addr_ok && s_r.ldn == LDN_KBD) begin
			case (idx)
				IDX_ACT: begin
					rd_hit = 1'b1;
					rd_data = {7'h00, s_r.kbd_act};
				end
				IDX_DBASE_HI: begin
					rd_hit = 1'b1;
					rd_data = {5'h00, s_r.dbase_hi};
				end
				IDX_DBASE_LO: begin
					rd_hit = 1'b1;
					rd_data = {s_r.dbase_lo, DBASE_LO_FIXED};
				end
				IDX_CBASE_HI: begin
					rd_hit = 1'b1;
					rd_data = {5'h00, s_r.cbase_hi};
				end
				IDX_CBASE_LO: begin
					rd_hit = 1'b1;
					rd_data = {s_r.cbase_lo, CBASE_LO_FIXED};
				end
				IDX_IRQ_NUM: begin
					rd_hit = 1'b1;
					rd_data = s_r.k_num;
				end
				IDX_IRQ_TYPE: begin
					rd_hit = 1'b1;
					rd_data = {6'h00, s_r.k_type};
				end
				IDX_DMA_A, IDX_DMA_B: begin
					rd_hit = 1'b1;
					rd_data = DMA_NONE;
				end
				IDX_CFG: begin
					rd_hit = 1'b1;
					rd_data = {s_r.clk_sel, 5'h00, s_r.tri_en};
				end
				default: begin
					rd_hit = 1'b0;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		if (I_CE) begin
			// read data and error are prepared in the setup cycle so the
			// access phase can finish with no wait state
			if (setup) begin
				s_nxt.prdata = {24'h00_0000, rd_data};
				s_nxt.pslverr = !rd_hit;
			end
			if (access && I_PWRITE && rd_hit) begin
				if (idx == IDX_LDN) begin
					s_nxt.ldn = wd;
				end else if (s_r.ldn == LDN_MOUSE) begin
					case (idx)
						IDX_ACT: s_nxt.mouse_act = wd[ACT_BIT];
						IDX_IRQ_NUM: s_nxt.m_num = wd;
						IDX_IRQ_TYPE: s_nxt.m_type = wd[TYPE_MSB:0];
						default: s_nxt.m_num = s_r.m_num;
					endcase
				end else begin
					case (idx)
						IDX_ACT: s_nxt.kbd_act = wd[ACT_BIT];
						IDX_DBASE_HI: s_nxt.dbase_hi = wd[BASE_HI_MSB:0];
						IDX_DBASE_LO: s_nxt.dbase_lo = wd[7:BASE_LO_LSB];
						IDX_CBASE_HI: s_nxt.cbase_hi = wd[BASE_HI_MSB:0];
						IDX_CBASE_LO: s_nxt.cbase_lo = wd[7:BASE_LO_LSB];
						IDX_IRQ_NUM: s_nxt.k_num = wd;
						IDX_IRQ_TYPE: s_nxt.k_type = wd[TYPE_MSB:0];
						IDX_CFG: begin
							// taken as written; core must be idle
							s_nxt.clk_sel = kmc_clk_sel_t'(wd_clk);
							s_nxt.tri_en = wd[CFG_TRI_BIT];
						end
						default: s_nxt.k_num = s_r.k_num;
					endcase
				end
			end
			// line 0 is never driven; it doubles as "no interrupt"
			s_nxt.irq = '0;
			for (int i = 1; i < NUM_IRQ; i++) begin
				if (s_r.mouse_act && I_MOUSE_IRQ_REQ && s_r.m_num[3:0] == 4'(i)) begin
					s_nxt.irq[i] = 1'b1;
				end
				if (I_KBD_IRQ_REQ && s_r.k_num[3:0] == 4'(i)) begin
					s_nxt.irq[i] = 1'b1;
				end
			end
			for (int p = 0; p < NUM_PINS; p++) begin
				s_nxt.pin_oe[p] = I_CORE_PULL_LOW[p];
			end
			if (s_r.tri_en && !s_r.kbd_act) begin
				s_nxt.pin_oe[PIN_TYP_CLK] = 1'b0;
				s_nxt.pin_oe[PIN_TYP_DAT] = 1'b0;
			end
			if (s_r.tri_en && !s_r.mouse_act) begin
				s_nxt.pin_oe[PIN_PTR_CLK] = 1'b0;
				s_nxt.pin_oe[PIN_PTR_DAT] = 1'b0;
			end
		end
		if (I_SRST) begin
			s_nxt = rst_state;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		s_r <= s_nxt;
	end

	// -------------------------------------------------------------------
	// pins and outputs
	// -------------------------------------------------------------------
	kmc_sync #(
		.WIDTH(NUM_PINS)
	) kmc_sync_inst (
		.i_clk(I_SYS_CLK),
		.i_srst(I_SRST),
		.i_ce(I_CE),
		.i_async(I_DEV_PIN_IN),
		.o_sync(O_CORE_PIN_IN)
	);

	// open drain: only ever drives low
	assign O_DEV_PIN_O = '0;
	assign O_DEV_PIN_OE = s_r.pin_oe;
	assign O_PREADY = 1'b1;
	assign O_PRDATA = s_r.prdata;
	assign O_PSLVERR = s_r.pslverr;
	assign O_IRQ = s_r.irq;
	assign O_KBD_IRQ_TYPE = s_r.k_type;
	assign O_MOUSE_IRQ_TYPE = s_r.m_type;
	assign O_KBD_ACTIVE = s_r.kbd_act;
	// mouse activation gates nothing on the host command path
	assign O_MOUSE_ACTIVE = s_r.mouse_act;
	assign O_CLK_SEL = s_r.clk_sel;
	assign O_CLK_SEL_OK = (s_r.clk_sel != CLK_RSVD);
	assign O_KBD_DATA_BASE = {5'h00, s_r.dbase_hi, s_r.dbase_lo,
		DBASE_LO_FIXED};
	assign O_KBD_CMD_BASE = {5'h00, s_r.cbase_hi, s_r.cbase_lo,
		CBASE_LO_FIXED};

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SRST);

	sequence rd_setup(logic [7:0] ix, logic [7:0] ld);
		I_CE && setup && !I_PWRITE && addr_ok && idx == ix && s_r.ldn == ld;
	endsequence

	sequence wr_access(logic [7:0] ix, logic [7:0] ld);
		I_CE && access && I_PWRITE && addr_ok && idx == ix && s_r.ldn == ld;
	endsequence

	mouse_irq_gate_a: assert property (
		I_CE && !s_r.mouse_act && !I_KBD_IRQ_REQ |=> O_IRQ == '0)
		else $error("inactive mouse drove an interrupt line");
	mouse_type_ro_a: assert property (
		rd_setup(IDX_IRQ_TYPE, LDN_MOUSE) |=> O_PRDATA[31:2] == '0)
		else $error("mouse interrupt type upper bits not zero");
	kbd_type_wr_a: assert property (
		wr_access(IDX_IRQ_TYPE, LDN_KBD)
		|=> O_KBD_IRQ_TYPE == $past(I_PWDATA[TYPE_MSB:0]))
		else $error("keyboard interrupt type write lost");
	data_base_fix_a: assert property (
		wr_access(IDX_DBASE_LO, LDN_KBD)
		|=> O_KBD_DATA_BASE[7:BASE_LO_LSB] == $past(I_PWDATA[7:BASE_LO_LSB])
		&& O_KBD_DATA_BASE[2:0] == DBASE_LO_FIXED
		&& O_KBD_DATA_BASE[15:11] == 5'h00)
		else $error("keyboard data base write or fixed bits wrong");
	cmd_base_fix_a: assert property (
		wr_access(IDX_CBASE_LO, LDN_KBD)
		|=> O_KBD_CMD_BASE[7:BASE_LO_LSB] == $past(I_PWDATA[7:BASE_LO_LSB])
		&& O_KBD_CMD_BASE[2:0] == CBASE_LO_FIXED
		&& O_KBD_CMD_BASE[15:11] == 5'h00)
		else $error("keyboard command base write or fixed bits wrong");
	dma_report_a: assert property (
		rd_setup(IDX_DMA_B, LDN_MOUSE) or rd_setup(IDX_DMA_A, LDN_KBD)
		|=> O_PRDATA == 32'h0000_0004 && !O_PSLVERR)
		else $error("dma report did not read 04h");
	reset_values_a: assert property (
		$fell(I_SRST) |-> O_CLK_SEL == CLK_12MHZ && O_IRQ == '0
		&& O_KBD_ACTIVE && !O_MOUSE_ACTIVE
		&& s_r.k_num == 8'h01 && s_r.m_num == 8'h0C)
		else $error("reset values wrong after release");
	clk_sel_wr_a: assert property (
		wr_access(IDX_CFG, LDN_KBD) |=> O_CLK_SEL == $past(wd_clk))
		else $error("clock select write not taken");
	cfg_rsvd_a: assert property (
		rd_setup(IDX_CFG, LDN_KBD)
		|=> O_PRDATA[5:1] == 5'h00 && O_PRDATA[31:8] == '0)
		else $error("configuration reserved bits not zero");
	kbd_float_a: assert property (
		I_CE && s_r.tri_en && !s_r.kbd_act
		|=> !O_DEV_PIN_OE[PIN_TYP_CLK] && !O_DEV_PIN_OE[PIN_TYP_DAT])
		else $error("inactive keyboard pins driven");
	ptr_float_a: assert property (
		I_CE && s_r.tri_en && !s_r.mouse_act
		|=> !O_DEV_PIN_OE[PIN_PTR_CLK] && !O_DEV_PIN_OE[PIN_PTR_DAT])
		else $error("inactive mouse pins driven");
	// reset still acts with the enable low; the default disable covers it
	ce_hold_a: assert property (
		!I_CE |=> $stable(O_IRQ) && $stable(O_CLK_SEL)
		&& $stable(O_DEV_PIN_OE) && $stable(O_CORE_PIN_IN))
		else $error("state moved while clock enable was low");
	// with floating off the pins follow the core whatever the activation
	pin_pass_a: assert property (
		I_CE && !s_r.tri_en |=> O_DEV_PIN_OE == $past(I_CORE_PULL_LOW))
		else $error("pins did not follow the core requests");
	kbd_irq_route_a: assert property (
		I_CE && I_KBD_IRQ_REQ && s_r.k_num[3:0] != 4'h0
		|=> O_IRQ[$past(s_r.k_num[3:0])])
		else $error("keyboard request missed its line");

endmodule
`default_nettype wire

// *** sim/kmc_config_bank_bench.sv ***
// self-checking bench for the mouse and keyboard configuration bank
// assumes the bank answers apb with zero wait states and a 250 MHz clock
`timescale 1ns/1ns
`default_nettype none
module kmc_config_bank_bench
	import kmc_pkg::*;
;

	// ---------------------------------------------------------------
	// clock, reset and design hookup
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic kbd_req = 1'b0;
	logic mouse_req = 1'b0;
	logic [NUM_PINS-1:0] pull_low = 4'h0;
	logic [NUM_PINS-1:0] pin_in = 4'hF;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic [NUM_IRQ-1:0] irq;
	logic [1:0] clk_sel;
	logic clk_ok;
	logic [NUM_PINS-1:0] core_in;
	logic [NUM_PINS-1:0] pin_o;
	logic [NUM_PINS-1:0] pin_oe;
	logic [1:0] kbd_type;
	logic [1:0] mouse_type;
	logic kbd_act;
	logic mouse_act;
	logic [15:0] data_base;
	logic [15:0] cmd_base;
	logic [32:0] notes[$];
	logic [32:0] note;
	logic [31:0] r;
	int n_fail = 0;
	int n_compared = 0;

	always #2 clk = ~clk;

	kmc_config_bank kmc_config_bank_inst (
		.I_SYS_CLK(clk), .I_SRST(srst), .I_CE(ce),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
		.O_PRDATA(prdata), .O_PSLVERR(pslverr),
		.I_KBD_IRQ_REQ(kbd_req), .I_MOUSE_IRQ_REQ(mouse_req),
		.O_IRQ(irq), .O_KBD_IRQ_TYPE(kbd_type),
		.O_MOUSE_IRQ_TYPE(mouse_type),
		.O_KBD_ACTIVE(kbd_act), .O_MOUSE_ACTIVE(mouse_act),
		.O_CLK_SEL(clk_sel), .O_CLK_SEL_OK(clk_ok),
		.O_KBD_DATA_BASE(data_base), .O_KBD_CMD_BASE(cmd_base),
		.I_CORE_PULL_LOW(pull_low), .O_CORE_PIN_IN(core_in),
		.I_DEV_PIN_IN(pin_in), .O_DEV_PIN_O(pin_o),
		.O_DEV_PIN_OE(pin_oe)
	);

	// ---------------------------------------------------------------
	// comparison, closing and bus tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// holds the request until pready is seen, then one idle cycle
	task automatic apb(input logic wr, input logic [7:0] idx,
			input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
			input logic err);
		notes.push_back({err, 24'h00_0000, exp});
		apb(1'b0, idx, 8'h00);
	endtask

	// lets n edges land, checks a port, then realigns to an edge
	task automatic port_chk(input int n, input logic [63:0] seen_sel,
			input logic [63:0] exp);
		repeat (n) @(posedge clk);
		#1;
		case (seen_sel)
			0: check(irq, exp);
			1: check(pin_oe, exp);
			2: check({clk_ok, clk_sel}, exp);
			4: check({kbd_type, mouse_type, kbd_act, mouse_act}, exp);
			5: check({data_base, cmd_base}, exp);
			default: check(core_in, exp);
		endcase
		@(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// read-data watcher: oldest note against the access-phase answer
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
				&& pwrite === 1'b0) begin
			note = notes.pop_front();
			check({pslverr, prdata}, note);
		end
	end

	initial begin
		#100000;
		n_fail++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		r = $urandom(47);
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		// keyboard device is selected after reset
		rd(IDX_ACT, 8'h01, 1'b0);
		rd(IDX_DBASE_HI, 8'h00, 1'b0);
		rd(IDX_DBASE_LO, 8'h60, 1'b0);
		rd(IDX_CBASE_HI, 8'h00, 1'b0);
		rd(IDX_CBASE_LO, 8'h64, 1'b0);
		rd(IDX_IRQ_NUM, 8'h01, 1'b0);
		rd(IDX_IRQ_TYPE, 8'h02, 1'b0);
		rd(IDX_DMA_A, 8'h04, 1'b0);
		rd(IDX_DMA_B, 8'h04, 1'b0);
		rd(IDX_CFG, 8'h40, 1'b0);
		port_chk(0, 2, 3'b101);
		port_chk(0, 4, 6'h2A);
		port_chk(0, 5, 32'h0060_0064);
		wr(IDX_IRQ_TYPE, 8'hFF);
		rd(IDX_IRQ_TYPE, 8'h03, 1'b0);
		wr(IDX_DMA_A, 8'hFF);
		rd(IDX_DMA_A, 8'h04, 1'b0);
		wr(IDX_DBASE_HI, 8'hFF);
		rd(IDX_DBASE_HI, 8'h07, 1'b0);
		wr(IDX_DBASE_LO, 8'hFF);
		rd(IDX_DBASE_LO, 8'hF8, 1'b0);
		wr(IDX_CBASE_LO, 8'h00);
		rd(IDX_CBASE_LO, 8'h04, 1'b0);
		port_chk(0, 5, 32'h07F8_0004);
		rd(8'h50, 8'h00, 1'b1);
		// clock changes only with both devices inactive
		wr(IDX_ACT, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(IDX_CFG, {s[1:0], 6'h00});
			rd(IDX_CFG, {s[1:0], 6'h00}, 1'b0);
			port_chk(0, 2, {s[1:0] != 2'b11, s[1:0]});
		end
		// back to the default clock before anything is reactivated
		wr(IDX_CFG, RST_CFG);
		wr(IDX_ACT, 8'h01);
		// mouse device
		wr(IDX_LDN, LDN_MOUSE);
		rd(IDX_ACT, 8'h00, 1'b0);
		rd(IDX_IRQ_NUM, 8'h0C, 1'b0);
		rd(IDX_IRQ_TYPE, 8'h02, 1'b0);
		rd(IDX_DMA_B, 8'h04, 1'b0);
		wr(IDX_IRQ_TYPE, 8'hFD);
		rd(IDX_IRQ_TYPE, 8'h01, 1'b0);
		port_chk(0, 4, 6'h36);
		port_chk(0, 0, 16'h0000);
		mouse_req <= 1'b1;
		port_chk(2, 0, 16'h0000);
		wr(IDX_ACT, 8'h01);
		port_chk(1, 0, 16'h1000);
		mouse_req <= 1'b0;
		kbd_req <= 1'b1;
		port_chk(2, 0, 16'h0002);
		kbd_req <= 1'b0;
		port_chk(2, 0, 16'h0000);
		// enable low: a request must not reach the line until it returns
		ce <= 1'b0;
		kbd_req <= 1'b1;
		port_chk(2, 0, 16'h0000);
		ce <= 1'b1;
		port_chk(1, 0, 16'h0002);
		kbd_req <= 1'b0;
		r = $urandom;
		wr(IDX_IRQ_NUM, r[7:0]);
		rd(IDX_IRQ_NUM, r[7:0], 1'b0);
		// pin floating: mouse inactive, keyboard active, float on
		wr(IDX_ACT, 8'h00);
		wr(IDX_LDN, LDN_KBD);
		wr(IDX_CFG, 8'h41);
		pull_low <= 4'hF;
		port_chk(2, 1, 4'h3);
		wr(IDX_ACT, 8'h00);
		port_chk(1, 1, 4'h0);
		wr(IDX_CFG, 8'h40);
		port_chk(1, 1, 4'hF);
		check(pin_o, 4'h0);
		r = $urandom;
		pin_in <= r[3:0];
		port_chk(3, 3, r[3:0]);
		finish_test();
	end

endmodule
`default_nettype wire
